/* logic/vss_defines.svh */
// timing, level and register map constants for the valley-skip switch timing block
`ifndef VSS_DEFINES_SVH
`define VSS_DEFINES_SVH
`define VSS_CLK_MHZ 100
`define VSS_MS_CYC(ms) ((ms) * 1000 * `VSS_CLK_MHZ)
`define VSS_US_CYC(us) ((us) * `VSS_CLK_MHZ)
`define VSS_NS_CYC_UP(ns) (((ns) * `VSS_CLK_MHZ + 999) / 1000)
`define VSS_SS_TOTAL_MS 12
`define VSS_SS_STEPS 4
`define VSS_PERIOD_MS 48
`define VSS_RS_LONG_NS 5000
`define VSS_RS_SHORT_NS 2500
`define VSS_MAX_OFF_US 50
`define VSS_MAX_ON_US 20
`define VSS_OVP_BLANK_US 1
`define VSS_LVL0_MV 10'h140
`define VSS_LVL1_MV 10'h223
`define VSS_LVL2_MV 10'h305
`define VSS_LVL3_MV 10'h3E8
`define VSS_TGT_MIN 3'h1
`define VSS_TGT_MAX 3'h7
`define VSS_ZC_MAX 3'h7
`define VSS_REG_CTRL 4'h0
`define VSS_REG_STATUS 4'h4
`define VSS_REG_LIMIT 4'h8
`define VSS_CTRL_RST 1'h1
`define VSS_RESP_OKAY 2'h0
`define VSS_RESP_SLVERR 2'h2
`endif

/* logic/vss_pkg.sv */
// types shared by the valley-skip switch timing block
package vss_pkg;
	typedef struct packed {
		logic high_line;
		logic supply_good;
		logic cs_trip;
		logic vs_rs_low;
		logic vs_ovp;
		logic vs_low;
		logic fb_reset;
		logic fb_down;
		logic fb_up;
	} vss_cmp_s;
	typedef struct packed {
		logic fb_reset;
		logic fb_down;
		logic fb_up;
	} vss_fb_s;
	typedef struct packed {
		logic threshold_select;
		logic rsvd3;
		logic [2:0] zc_count;
		logic rsvd2;
		logic [2:0] target;
		logic [1:0] rsvd1;
		logic [1:0] ss_step;
		logic ss_done;
		logic gate;
		logic latched;
		logic running;
	} vss_status_s;
	typedef enum logic [2:0] {ST_IDLE, ST_ON, ST_SUPPRESS, ST_WAIT, ST_LATCH} vss_gate_e;
endpackage

/* logic/vss_updown.sv */
// valley-target up/down counter stepped once per evaluation period
`timescale 1ns/1ps
`default_nettype none
`include "vss_defines.svh"
module vss_updown (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic init,
	input wire logic tick,
	input wire vss_pkg::vss_fb_s fb,
	output logic [2:0] target
);
	logic seen_up, seen_down, seen_rst;
	wire any_up = seen_up | fb.fb_up;
	wire any_down = seen_down | fb.fb_down;
	wire any_rst = seen_rst | fb.fb_reset;
	wire at_max = target == `VSS_TGT_MAX;
	wire at_min = target == `VSS_TGT_MIN;
	wire [2:0] next_target = any_rst ? `VSS_TGT_MIN :
		any_down ? (at_min ? target : target - 3'h1) :
		any_up ? target :
		(at_max ? target : target + 3'h1);
	// current sample joins the decision, so a crossing at the boundary is kept
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			target <= `VSS_TGT_MIN;
			seen_up <= 1'b0;
			seen_down <= 1'b0;
			seen_rst <= 1'b0;
		end else if (init || tick) begin
			target <= init ? `VSS_TGT_MIN : next_target;
			seen_up <= 1'b0;
			seen_down <= 1'b0;
			seen_rst <= 1'b0;
		end else begin
			seen_up <= any_up;
			seen_down <= any_down;
			seen_rst <= any_rst;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_reset_to_min: assert property (tick && any_rst |=> target == `VSS_TGT_MIN) else $error("reset threshold did not force minimum");
	chk_count_up: assert property (tick && !init && !any_up && !at_max |=> target == $past(target) + 3'h1) else $error("counter did not step up");
	chk_hold_value: assert property (tick && !init && any_up && !any_down && !any_rst |=> $stable(target)) else $error("counter changed in hold band");
	chk_count_down: assert property (tick && !init && any_down && !any_rst && !at_min |=> target == $past(target) - 3'h1) else $error("counter did not step down");
	chk_target_range: assert property (target >= `VSS_TGT_MIN && target <= `VSS_TGT_MAX) else $error("target out of range");
	chk_init_min: assert property (init |=> target == `VSS_TGT_MIN) else $error("start did not load minimum");
	chk_only_on_tick: assert property (!tick && !init |=> $stable(target)) else $error("target changed between periods");
endmodule
`default_nettype wire

/* logic/vss_zc_counter.sv */
// zero-crossing counter of valley-sense falling crossings while the switch is off
`timescale 1ns/1ps
`default_nettype none
`include "vss_defines.svh"
module vss_zc_counter (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clear,
	input wire logic gate,
	input wire logic vs_low,
	output logic [2:0] count
);
	logic vs_low_d;
	wire crossing = vs_low & ~vs_low_d & ~gate;
	wire sat = count == `VSS_ZC_MAX;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vs_low_d <= 1'b0;
			count <= 3'h0;
		end else begin
			vs_low_d <= vs_low;
			if (clear)
				count <= 3'h0;
			else if (crossing && !sat)
				count <= count + 3'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_zc_clear: assert property (clear |=> count == 3'h0) else $error("counter not cleared at gate rise");
	chk_zc_bound: assert property (sat && !clear |=> sat) else $error("counter left its maximum");
	chk_zc_step: assert property (crossing && !sat && !clear |=> count == $past(count) + 3'h1) else $error("crossing not counted");
endmodule
`default_nettype wire

/* logic/vss_switch_timing.sv */
// switch-on timing, soft-start, valley control and overvoltage latch with an AXI4-Lite register port
`timescale 1ns/1ps
`default_nettype none
`include "vss_defines.svh"
// Summary of operation
// - supply good: stop start-up cell, begin soft-start
// - soft-start is digital, 12ms in 4 steps
// - limit climbs 0.32V to 1V, lower limit wins
// - counters decide turn-on, comparator decides turn-off
// - target counter holds valley index for turn-on
// - feedback judged once per 48ms period
// - always below low threshold: count up
// - above low, never high: hold value
// - above high, never reset: count down
// - above reset threshold: force to one
// - counter saturates at one and seven
// - counter starts at one
// - counting thresholds follow line level
// - zero-crossing counter bounded zero to seven
// - each falling valley crossing when off counts
// - gate rising clears zero-crossing counter
// - overvoltage while off latches after blanking
// - after suppression, turn on when count reaches target
// - gate held low through suppression, longer if low
// - maximum off time forces turn-on
// - maximum on time forces turn-off
module vss_switch_timing #(
	parameter int unsigned SS_TOTAL_CYC = `VSS_MS_CYC(`VSS_SS_TOTAL_MS),
	parameter int unsigned PERIOD_CYC = `VSS_MS_CYC(`VSS_PERIOD_MS),
	parameter int unsigned RS_LONG_CYC = `VSS_NS_CYC_UP(`VSS_RS_LONG_NS),
	parameter int unsigned RS_SHORT_CYC = `VSS_NS_CYC_UP(`VSS_RS_SHORT_NS),
	parameter int unsigned MAX_OFF_CYC = `VSS_US_CYC(`VSS_MAX_OFF_US),
	parameter int unsigned MAX_ON_CYC = `VSS_US_CYC(`VSS_MAX_ON_US),
	parameter int unsigned OVP_BLANK_CYC = `VSS_US_CYC(`VSS_OVP_BLANK_US)
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire vss_pkg::vss_cmp_s cmp_in,
	input wire logic [9:0] foldback_limit_mv,
	output logic gate_drive_output,
	output logic startup_cell_en,
	output logic [9:0] cs_limit_mv,
	output logic threshold_select,
	output logic latched_off,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int unsigned TW = 24;
	localparam int unsigned SS_STEP_CYC = SS_TOTAL_CYC / `VSS_SS_STEPS;

	// pin comparators pass two flops before use
	logic [8:0] sync_a, sync_b;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_a <= 9'h000;
			sync_b <= 9'h000;
		end else begin
			sync_a <= cmp_in;
			sync_b <= sync_a;
		end
	end
	vss_pkg::vss_cmp_s cmp;
	assign cmp = vss_pkg::vss_cmp_s'(sync_b);

	// start-up handoff
	logic ctrl_en, supply_d, running;
	wire supply_rise = cmp.supply_good & ~supply_d;
	wire next_running = cmp.supply_good & ctrl_en & ~latched_off & (running | supply_rise);
	wire start = next_running & ~running;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			supply_d <= 1'b0;
			running <= 1'b0;
			startup_cell_en <= 1'b1;
		end else begin
			supply_d <= cmp.supply_good;
			running <= next_running;
			if (start)
				startup_cell_en <= 1'b0;
		end
	end

	// soft-start: four equal steps of the peak limit
	logic [TW-1:0] ss_cnt;
	logic [1:0] ss_step;
	logic ss_done;
	wire ss_step_end = ss_cnt == TW'(SS_STEP_CYC - 1);
	wire [9:0] ss_level = (ss_step == 2'h0) ? `VSS_LVL0_MV :
		(ss_step == 2'h1) ? `VSS_LVL1_MV :
		(ss_step == 2'h2) ? `VSS_LVL2_MV : `VSS_LVL3_MV;
	wire [9:0] next_limit = (foldback_limit_mv < ss_level) ? foldback_limit_mv : ss_level;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ss_cnt <= '0;
			ss_step <= 2'h0;
			ss_done <= 1'b0;
			cs_limit_mv <= `VSS_LVL0_MV;
		end else begin
			cs_limit_mv <= next_limit;
			if (start) begin
				ss_cnt <= '0;
				ss_step <= 2'h0;
				ss_done <= 1'b0;
			end else if (running && !ss_done) begin
				ss_cnt <= ss_step_end ? '0 : ss_cnt + TW'(1);
				if (ss_step_end && ss_step == 2'h3)
					ss_done <= 1'b1;
				else if (ss_step_end)
					ss_step <= ss_step + 2'h1;
			end
		end
	end

	// evaluation period divider
	logic [TW-1:0] per_cnt;
	wire per_tick = running & (per_cnt == TW'(PERIOD_CYC - 1));
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			per_cnt <= '0;
		else if (start || per_tick)
			per_cnt <= '0;
		else if (running)
			per_cnt <= per_cnt + TW'(1);
	end

	// counting thresholds follow the line level
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			threshold_select <= 1'b0;
		else
			threshold_select <= cmp.high_line;
	end

	logic [2:0] target, zc_count;
	vss_pkg::vss_fb_s fb;
	assign fb = '{fb_reset: cmp.fb_reset, fb_down: cmp.fb_down, fb_up: cmp.fb_up};
	vss_updown u_updown (
		.clk(clk),
		.arst_n(arst_n),
		.init(start),
		.tick(per_tick),
		.fb(fb),
		.target(target)
	);

	// gate sequencing
	vss_pkg::vss_gate_e state, next_state;
	logic [TW-1:0] on_cnt, off_cnt, rs_cnt, ovp_cnt;
	wire valley_ok = zc_count >= target;
	wire maxoff_hit = off_cnt >= TW'(MAX_OFF_CYC - 1);
	wire maxon_hit = on_cnt == TW'(MAX_ON_CYC - 1);
	wire turn_off = cmp.cs_trip | maxon_hit;
	wire ovp_armed = cmp.vs_ovp & ~gate_drive_output & running;
	wire ovp_hit = ovp_armed & (ovp_cnt == TW'(OVP_BLANK_CYC - 1));
	wire [TW-1:0] rs_load = cmp.vs_rs_low ? TW'(RS_LONG_CYC - 1) : TW'(RS_SHORT_CYC - 1);
	wire turn_on_ok = start | (state == vss_pkg::ST_WAIT & (valley_ok | maxoff_hit));
	wire zc_clear = (next_state == vss_pkg::ST_ON) & ~gate_drive_output;

	always_comb begin
		next_state = state;
		unique case (state)
			vss_pkg::ST_IDLE: if (start) next_state = vss_pkg::ST_ON;
			vss_pkg::ST_ON: if (turn_off) next_state = vss_pkg::ST_SUPPRESS;
			vss_pkg::ST_SUPPRESS: if (rs_cnt == '0) next_state = vss_pkg::ST_WAIT;
			vss_pkg::ST_WAIT: if (valley_ok || maxoff_hit) next_state = vss_pkg::ST_ON;
			vss_pkg::ST_LATCH: next_state = vss_pkg::ST_LATCH;
		endcase
		if (ovp_hit)
			next_state = vss_pkg::ST_LATCH;
		else if (!running && state != vss_pkg::ST_LATCH && !start)
			next_state = vss_pkg::ST_IDLE;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= vss_pkg::ST_IDLE;
			gate_drive_output <= 1'b0;
			latched_off <= 1'b0;
		end else begin
			state <= next_state;
			gate_drive_output <= next_state == vss_pkg::ST_ON;
			if (ovp_hit)
				latched_off <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			on_cnt <= '0;
			off_cnt <= '0;
			rs_cnt <= '0;
			ovp_cnt <= '0;
		end else begin
			on_cnt <= (state == vss_pkg::ST_ON && next_state == vss_pkg::ST_ON) ? on_cnt + TW'(1) : '0;
			off_cnt <= (next_state == vss_pkg::ST_SUPPRESS || next_state == vss_pkg::ST_WAIT) ?
				((state == vss_pkg::ST_ON) ? '0 : off_cnt + TW'(1)) : '0;
			if (state == vss_pkg::ST_ON)
				rs_cnt <= rs_load;
			else if (rs_cnt != '0)
				rs_cnt <= rs_cnt - TW'(1);
			ovp_cnt <= (ovp_armed && !ovp_hit) ? ovp_cnt + TW'(1) : '0;
		end
	end

	vss_zc_counter u_zc (
		.clk(clk),
		.arst_n(arst_n),
		.clear(zc_clear),
		.gate(gate_drive_output),
		.vs_low(cmp.vs_low),
		.count(zc_count)
	);

	// register port
	logic aw_got, w_got;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire do_write = aw_got & w_got;
	wire [3:0] wr_off = {aw_addr[3:2], 2'h0};
	wire [3:0] rd_off = {s_axi_araddr[3:2], 2'h0};
	wire wr_ctrl = wr_off == `VSS_REG_CTRL;
	wire wr_mapped = wr_ctrl | (wr_off == `VSS_REG_STATUS) | (wr_off == `VSS_REG_LIMIT);
	vss_pkg::vss_status_s status;
	assign status = '{threshold_select: threshold_select, rsvd3: 1'b0, zc_count: zc_count, rsvd2: 1'b0,
		target: target, rsvd1: 2'h0, ss_step: ss_step, ss_done: ss_done, gate: gate_drive_output,
		latched: latched_off, running: running};
	wire rd_mapped = (rd_off == `VSS_REG_CTRL) | (rd_off == `VSS_REG_STATUS) | (rd_off == `VSS_REG_LIMIT);
	wire [31:0] rd_mux = (rd_off == `VSS_REG_CTRL) ? {31'h0000_0000, ctrl_en} :
		(rd_off == `VSS_REG_STATUS) ? {15'h0000, status} :
		(rd_off == `VSS_REG_LIMIT) ? {22'h00_0000, cs_limit_mv} : 32'h0000_0000;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `VSS_RESP_OKAY;
			ctrl_en <= `VSS_CTRL_RST;
		end else begin
			if (aw_hs) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_hs) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `VSS_RESP_OKAY : `VSS_RESP_SLVERR;
				if (wr_ctrl && w_strb[0])
					ctrl_en <= w_data[0];
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `VSS_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_mapped ? `VSS_RESP_OKAY : `VSS_RESP_SLVERR;
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_gate_fell;
		$fell(gate_drive_output);
	endsequence
	sequence s_ovp_done;
		ovp_hit ##1 latched_off;
	endsequence
	chk_cell_off: assert property ($rose(running) |-> !startup_cell_en) else $error("start-up cell still on");
	chk_ss_first: assert property ($rose(running) |=> ss_step == 2'h0 ##1 cs_limit_mv <= `VSS_LVL0_MV) else $error("soft-start not at lowest level");
	chk_ss_step: assert property ($changed(ss_step) && $past(running) && !$rose(running) |-> $past(ss_step_end)) else $error("soft-start step off boundary");
	chk_limit_min: assert property (cs_limit_mv > foldback_limit_mv |-> $changed(foldback_limit_mv)) else $error("limit above foldback");
	chk_rs_hold: assert property (s_gate_fell |-> !gate_drive_output [*2]) else $error("gate rose inside suppression");
	chk_turn_on_cause: assert property ($rose(gate_drive_output) |-> $past(turn_on_ok)) else $error("turn-on without valley or max off");
	chk_maxoff_on: assert property (state == vss_pkg::ST_WAIT && maxoff_hit && !ovp_hit && running |=> gate_drive_output) else $error("max off did not force turn-on");
	chk_maxon_off: assert property (gate_drive_output && maxon_hit |=> !gate_drive_output) else $error("max on did not force turn-off");
	chk_ovp_latch: assert property (ovp_hit |-> s_ovp_done) else $error("overvoltage not latched");
	chk_latch_holds: assert property (latched_off |-> !gate_drive_output ##1 (!gate_drive_output && !running)) else $error("switching while latched off");
endmodule
`default_nettype wire

/* tb/vss_power_stage.sv */
// flyback power stage model: shunt trip after a set on time, valley ringing after turn-off
`timescale 1ns/1ps
`default_nettype none
module vss_power_stage (
	input wire logic clk,
	input wire logic gate,
	input wire logic [7:0] on_cyc,
	input wire logic [3:0] rings,
	output logic cs_trip,
	output logic vs_low
);
	logic gate_q;
	int cnt;
	int n;
	initial begin
		gate_q = 1'b0;
		cnt = 0;
		n = 0;
		cs_trip = 1'b0;
		vs_low = 1'b0;
	end
	// sense pin is clamped low while on; off time starts above the threshold, one valley per ring
	always @(posedge clk) begin
		n = (gate != gate_q) ? 0 : cnt + 1;
		gate_q <= gate;
		cnt <= n;
		cs_trip <= gate && cnt >= on_cyc;
		vs_low <= gate || (n < 4 * rings && n[1]);
	end
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the valley-skip switch timing block
`timescale 1ns/1ps
`default_nettype none
`include "vss_defines.svh"
module tb;
	localparam int SS = 400;
	localparam int PER = 200;
	localparam int RSL = 8;
	localparam int RSS = 4;
	localparam int MOFF = 40;
	localparam int MON = 20;
	localparam int BLK = 5;
	logic clk, arst_n, gate, sc_en, thr, lat, ps_cs, ps_vs;
	vss_pkg::vss_cmp_s drv, cmp;
	logic [9:0] fold, lim;
	logic [7:0] on_cyc;
	logic [3:0] rings, awaddr, araddr, wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0;
	always_comb begin
		cmp = drv;
		cmp.cs_trip = ps_cs;
		cmp.vs_low = ps_vs;
	end
	vss_switch_timing #(.SS_TOTAL_CYC(SS), .PERIOD_CYC(PER), .RS_LONG_CYC(RSL), .RS_SHORT_CYC(RSS),
		.MAX_OFF_CYC(MOFF), .MAX_ON_CYC(MON), .OVP_BLANK_CYC(BLK)) u_vss_switch_timing (
		.clk(clk), .arst_n(arst_n), .cmp_in(cmp), .foldback_limit_mv(fold), .gate_drive_output(gate),
		.startup_cell_en(sc_en), .cs_limit_mv(lim), .threshold_select(thr), .latched_off(lat),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	vss_power_stage u_vss_power_stage (.clk(clk), .gate(gate), .on_cyc(on_cyc), .rings(rings),
		.cs_trip(ps_cs), .vs_low(ps_vs));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hang guard, well above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic st(output logic [31:0] s);
		logic [1:0] r;
		rd(`VSS_REG_STATUS, s, r);
	endtask
	// low time then high time of the next full switching cycle
	task automatic meas(output int toff, output int ton);
		toff = 0;
		ton = 0;
		while (gate !== 1'b1) @(posedge clk);
		while (gate !== 1'b0) @(posedge clk);
		while (gate !== 1'b1) begin
			@(posedge clk);
			toff++;
		end
		while (gate !== 1'b0) begin
			@(posedge clk);
			ton++;
		end
	endtask
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		chk("startup_cell_en", 1, sc_en);
		chk("gate", 0, gate);
		chk("cs_limit_mv", `VSS_LVL0_MV, lim);
		rd(`VSS_REG_CTRL, d, r);
		chk("ctrl", 1, d);
		rd(4'hC, d, r);
		chk("rresp unmapped", `VSS_RESP_SLVERR, r);
		wr(4'hC, 32'h0000_0001, r);
		chk("bresp unmapped", `VSS_RESP_SLVERR, r);
		wr(`VSS_REG_STATUS, 32'hFFFF_FFFF, r);
		chk("bresp status", `VSS_RESP_OKAY, r);
		$display("test reset done");
	endtask
	task automatic t_start();
		logic [31:0] s;
		logic [9:0] lv[4];
		lv = '{`VSS_LVL0_MV, `VSS_LVL1_MV, `VSS_LVL2_MV, `VSS_LVL3_MV};
		drv.supply_good <= 1'b1;
		while (sc_en !== 1'b0) @(posedge clk);
		for (int k = 0; k < 4; k++) begin
			tick(k == 0 ? SS / 8 : SS / 4);
			chk("cs_limit_mv", lv[k], lim);
		end
		fold <= 10'h190;
		tick(3);
		chk("cs_limit_mv folded", 10'h190, lim);
		fold <= 10'h3E8;
		tick(SS / 4);
		st(s);
		chk("running", 1, s[0]);
		chk("ss_done", 1, s[3]);
		chk("target", `VSS_TGT_MIN, s[10:8]);
		drv.high_line <= 1'b1;
		tick(5);
		chk("threshold_select", 1, thr);
		$display("test start done");
	endtask
	task automatic t_sw();
		int tf, tn;
		meas(tf, tn);
		chk("on by shunt", 1, tn < MON);
		chk("off short", 1, tf >= RSS && tf < RSL);
		drv.vs_rs_low <= 1'b1;
		meas(tf, tn);
		chk("off long", 1, tf >= RSL && tf < MOFF - 4);
		on_cyc <= 8'd60;
		meas(tf, tn);
		chk("on max", 1, tn >= MON && tn <= MON + 2);
		on_cyc <= 8'd10;
		$display("test switching done");
	endtask
	task automatic t_zc();
		logic [31:0] s;
		int tf, tn;
		{drv.fb_reset, drv.fb_down, drv.fb_up} <= 3'b000;
		tick(8 * PER);
		st(s);
		chk("target", `VSS_TGT_MAX, s[10:8]);
		rings <= 4'd3;
		meas(tf, tn);
		chk("off max", 1, tf >= MOFF - 2 && tf <= MOFF + 2);
		while (gate !== 1'b0) @(posedge clk);
		tick(25);
		st(s);
		chk("zc_count", 3, s[14:12]);
		while (gate !== 1'b1) @(posedge clk);
		st(s);
		chk("zc_count cleared", 0, s[14:12]);
		rings <= 4'd0;
		while (gate !== 1'b0) @(posedge clk);
		drv.vs_ovp <= 1'b1;
		tick(BLK - 2);
		drv.vs_ovp <= 1'b0;
		tick(10);
		chk("latched_off", 0, lat);
		$display("test zero crossing done");
	endtask
	task automatic t_cnt();
		logic [2:0] f[5];
		logic [31:0] a, b;
		logic [2:0] e;
		f = '{3'b001, 3'b011, 3'b111, 3'b011, 3'b000};
		for (int i = 0; i < 5; i++) begin
			{drv.fb_reset, drv.fb_down, drv.fb_up} <= f[i];
			tick(PER + 8);
			st(a);
			tick(PER - 3);
			st(b);
			case (f[i])
				3'b000: e = (a[10:8] == 3'h7) ? 3'h7 : a[10:8] + 3'h1;
				3'b001: e = a[10:8];
				3'b011: e = (a[10:8] == 3'h1) ? 3'h1 : a[10:8] - 3'h1;
				default: e = `VSS_TGT_MIN;
			endcase
			chk("target step", e, b[10:8]);
		end
		{drv.fb_reset, drv.fb_down, drv.fb_up} <= 3'b111;
		tick(3);
		{drv.fb_reset, drv.fb_down, drv.fb_up} <= 3'b001;
		tick(PER + 8);
		st(b);
		chk("target after pulse", `VSS_TGT_MIN, b[10:8]);
		$display("test valley target done");
	endtask
	task automatic t_end();
		logic [31:0] s;
		logic [1:0] r;
		wr(`VSS_REG_CTRL, 32'h0000_0000, r);
		tick(60);
		chk("gate disabled", 0, gate);
		st(s);
		chk("running", 0, s[0]);
		wr(`VSS_REG_CTRL, 32'h0000_0001, r);
		drv.supply_good <= 1'b0;
		tick(4);
		drv.supply_good <= 1'b1;
		tick(10);
		st(s);
		chk("running again", 1, s[0]);
		while (gate !== 1'b1) @(posedge clk);
		while (gate !== 1'b0) @(posedge clk);
		drv.vs_ovp <= 1'b1;
		tick(BLK + 6);
		chk("latched_off", 1, lat);
		tick(MOFF + 10);
		chk("gate latched", 0, gate);
		$display("test overvoltage done");
	endtask
	initial begin
		arst_n = 1'b0;
		drv = '0;
		drv.fb_up = 1'b1;
		fold = 10'h3E8;
		on_cyc = 8'd10;
		rings = 4'd2;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		tick(16);
		arst_n <= 1'b1;
		tick(2);
		t_reset();
		t_start();
		t_sw();
		t_zc();
		t_cnt();
		t_end();
		test_done();
	end
endmodule
`default_nettype wire
